// >>> common/bwcr_pkg.sv
// Constants for the bridge window and control register bank
package bwcr_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] BWCR_OFF_PF_TOP_HIGH = 8'h2c;
	localparam logic [7:0] BWCR_OFF_IO_HIGH = 8'h30;
	localparam logic [7:0] BWCR_OFF_CAP_START = 8'h34;
	localparam logic [7:0] BWCR_OFF_IRQ_BCTL = 8'h3c;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] BWCR_PF_TOP_HIGH_RST = 32'h0000_0000;
	localparam logic [15:0] BWCR_IO_HALF_RST = 16'h0000;
	localparam logic [7:0] BWCR_CAP_START_VAL = 8'h40;
	localparam logic [7:0] BWCR_IRQ_LINE_RST = 8'h00;
	localparam logic [7:0] BWCR_IRQ_PIN_RST = 8'h00;

	// ----------------------------------------------------------------
	// Bridge control bit positions within the 3Ch word
	// ----------------------------------------------------------------
	localparam int BWCR_BC_POISON = 16;
	localparam int BWCR_BC_ERRFWD = 17;
	localparam int BWCR_BC_ISA = 18;
	localparam int BWCR_BC_VGA = 19;
	localparam int BWCR_BC_VGA16 = 20;
	localparam int BWCR_BC_SECRST = 22;

	// ----------------------------------------------------------------
	// Address decode constants
	// ----------------------------------------------------------------
	localparam logic [19:0] BWCR_PF_LOW_ONES = 20'hF_FFFF;
	localparam logic [31:0] BWCR_VGA_MEM_LO = 32'h000A_0000;
	localparam logic [31:0] BWCR_VGA_MEM_HI = 32'h000B_FFFF;
	localparam logic [9:0] BWCR_VGA_IO_A_LO = 10'h3b0;
	localparam logic [9:0] BWCR_VGA_IO_A_HI = 10'h3bb;
	localparam logic [9:0] BWCR_VGA_IO_B_LO = 10'h3c0;
	localparam logic [9:0] BWCR_VGA_IO_B_HI = 10'h3df;

endpackage : bwcr_pkg

// >>> src/bwcr_regs.sv
// Bridge window upper halves, capability start, interrupt and bridge control
//
// Operation
// - Prefetch window top bits 63:32, RW, zero
// - I/O window bottom bits 31:16, RW, zero
// - I/O window top bits 31:16, RW, zero
// - Capability start reads 40h
// - Hot-plug raises INTA; pin field reads 00h
// - Downstream pin default loadable before read
// - Bit 16 enables poisoned TLP reporting
// - Bit 17 forwards error messages upstream
// - Bit 18 clear: window I/O goes downstream
// - Bit 18 set: ISA aliases go upstream
// - Bit 19 forwards VGA memory range
// - VGA I/O ranges 3B0-3BB, 3C0-3DF
// - Bit 20 selects 10 or 16 bit decode
// - Bit 22 triggers hot reset
// - Downstream port: reset own attached device
// - Upstream port: reset all downstream ports
// - Bits 21, 23-27 read zero
// - Prefetch top low bits taken as ones
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module bwcr_regs
	import bwcr_pkg::*;
#(
	parameter int DN_PORTS = 5
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Port role and interrupt pin load
	input wire logic is_downstream,
	input wire logic pin_load_valid,
	input wire logic [7:0] pin_load_value,
	// Event inputs
	input wire logic hotplug_event,
	input wire logic poison_seen,
	input wire logic err_msg_seen,
	// I/O request decode
	input wire logic io_req_valid,
	input wire logic [31:0] io_req_addr,
	input wire logic [15:0] io_bottom_low,
	input wire logic [15:0] io_top_low,
	// Memory request decode
	input wire logic mem_req_valid,
	input wire logic [63:0] mem_req_addr,
	input wire logic [11:0] pf_top_mid,
	// Decode results
	output logic io_fwd_down,
	output logic io_fwd_up,
	output logic vga_fwd,
	output logic mem_below_pf_top,
	output logic dec_valid,
	// Event results
	output logic inta_assert,
	output logic poison_report,
	output logic err_msg_fwd,
	// Resets out
	output logic hot_reset_req,
	output logic [DN_PORTS-1:0] port_rst_n
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// VGA I/O alias check on the low ten address bits
	function automatic logic vga_io_hit(input logic [31:0] a,
		input logic wide);
		logic low_ok;
		low_ok = (a[9:0] >= BWCR_VGA_IO_A_LO && a[9:0] <= BWCR_VGA_IO_A_HI)
			|| (a[9:0] >= BWCR_VGA_IO_B_LO && a[9:0] <= BWCR_VGA_IO_B_HI);
		return low_ok && (a[31:16] == 16'h0000)
			&& (!wide || a[15:10] == 6'h00);
	endfunction : vga_io_hit

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [31:0] pf_top_high_q;
	logic [15:0] io_bottom_high_q;
	logic [15:0] io_top_high_q;
	logic [7:0] irq_line_q;
	logic [7:0] irq_pin_q;
	logic poison_en_q;
	logic err_fwd_en_q;
	logic isa_en_q;
	logic vga_en_q;
	logic vga16_q;
	logic sec_rst_q;
	logic [31:0] rdata_q;
	logic [15:0] bctl_word;
	logic wr_pf;
	logic wr_io;
	logic wr_irq;

	assign wr_pf = reg_wr && reg_addr == BWCR_OFF_PF_TOP_HIGH;
	assign wr_io = reg_wr && reg_addr == BWCR_OFF_IO_HIGH;
	assign wr_irq = reg_wr && reg_addr == BWCR_OFF_IRQ_BCTL;

	// Bridge control upper half; fixed bits tie to zero
	assign bctl_word = {4'h0, 5'h00, sec_rst_q, 1'b0, vga16_q, vga_en_q,
		isa_en_q, err_fwd_en_q, poison_en_q};

	// Prefetch window top upper word
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pf_top_high_q <= BWCR_PF_TOP_HIGH_RST;
		end else if (wr_pf) begin
			pf_top_high_q <= reg_wdata;
		end
	end

	// I/O window upper halves
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			io_bottom_high_q <= BWCR_IO_HALF_RST;
			io_top_high_q <= BWCR_IO_HALF_RST;
		end else if (wr_io) begin
			io_bottom_high_q <= reg_wdata[15:0];
			io_top_high_q <= reg_wdata[31:16];
		end
	end

	// Interrupt line scratch byte
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_line_q <= BWCR_IRQ_LINE_RST;
		end else if (wr_irq) begin
			irq_line_q <= reg_wdata[7:0];
		end
	end

	// Interrupt pin default, replaceable on downstream ports
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_pin_q <= BWCR_IRQ_PIN_RST;
		end else if (pin_load_valid && is_downstream) begin
			irq_pin_q <= pin_load_value;
		end
	end

	// Writable bridge control bits
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			poison_en_q <= 1'b0;
			err_fwd_en_q <= 1'b0;
			isa_en_q <= 1'b0;
			vga_en_q <= 1'b0;
			vga16_q <= 1'b0;
			sec_rst_q <= 1'b0;
		end else if (wr_irq) begin
			poison_en_q <= reg_wdata[BWCR_BC_POISON];
			err_fwd_en_q <= reg_wdata[BWCR_BC_ERRFWD];
			isa_en_q <= reg_wdata[BWCR_BC_ISA];
			vga_en_q <= reg_wdata[BWCR_BC_VGA];
			vga16_q <= reg_wdata[BWCR_BC_VGA16];
			sec_rst_q <= reg_wdata[BWCR_BC_SECRST];
		end
	end

	// ----------------------------------------------------------------
	// Read path: data valid only in the cycle after the strobe
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 32'h0000_0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				BWCR_OFF_PF_TOP_HIGH: rdata_q <= pf_top_high_q;
				BWCR_OFF_IO_HIGH: rdata_q <= {io_top_high_q, io_bottom_high_q};
				BWCR_OFF_CAP_START: rdata_q <= {24'h00_0000,
					BWCR_CAP_START_VAL};
				BWCR_OFF_IRQ_BCTL: rdata_q <= {bctl_word, irq_pin_q,
					irq_line_q};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end
	assign reg_rdata = rdata_q;

	// ----------------------------------------------------------------
	// Forwarding decode, registered one cycle after request
	// ----------------------------------------------------------------
	logic [31:0] io_lo;
	logic [31:0] io_hi;
	logic io_in_win;
	logic isa_alias;
	logic [63:0] pf_top_full;
	logic io_down_q;
	logic io_up_q;
	logic vga_q;
	logic mem_top_q;
	logic dec_valid_q;

	assign io_lo = {io_bottom_high_q, io_bottom_low};
	assign io_hi = {io_top_high_q, io_top_low};
	assign io_in_win = io_req_addr >= io_lo && io_req_addr <= io_hi;
	// Top 768 bytes of each 1KB block inside the first 64KB
	assign isa_alias = io_req_addr[31:16] == 16'h0000
		&& io_req_addr[9:8] != 2'b00;
	assign pf_top_full = {pf_top_high_q, pf_top_mid, BWCR_PF_LOW_ONES};

	// I/O direction decision
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			io_down_q <= 1'b0;
			io_up_q <= 1'b0;
		end else if (io_req_valid) begin
			io_down_q <= io_in_win && !(isa_en_q && isa_alias);
			io_up_q <= io_in_win && isa_en_q && isa_alias;
		end else begin
			io_down_q <= 1'b0;
			io_up_q <= 1'b0;
		end
	end

	// VGA memory and I/O decode
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			vga_q <= 1'b0;
		end else if (io_req_valid) begin
			vga_q <= vga_en_q && vga_io_hit(io_req_addr, vga16_q);
		end else if (mem_req_valid) begin
			vga_q <= vga_en_q && mem_req_addr >= {32'h0000_0000,
				BWCR_VGA_MEM_LO} && mem_req_addr <= {32'h0000_0000,
				BWCR_VGA_MEM_HI};
		end else begin
			vga_q <= 1'b0;
		end
	end

	// Prefetch top comparison and result strobe
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_top_q <= 1'b0;
			dec_valid_q <= 1'b0;
		end else begin
			mem_top_q <= mem_req_valid && mem_req_addr <= pf_top_full;
			dec_valid_q <= io_req_valid || mem_req_valid;
		end
	end
	assign io_fwd_down = io_down_q;
	assign io_fwd_up = io_up_q;
	assign vga_fwd = vga_q;
	assign mem_below_pf_top = mem_top_q;
	assign dec_valid = dec_valid_q;

	// ----------------------------------------------------------------
	// Events and resets
	// ----------------------------------------------------------------
	logic inta_q;
	logic poison_q;
	logic err_q;
	logic [DN_PORTS-1:0] prst_n_q;

	// Event registers; poison and error gated by control bits, hot-plug INTA ungated
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			inta_q <= 1'b0;
			poison_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			inta_q <= hotplug_event;
			poison_q <= poison_seen && poison_en_q;
			err_q <= err_msg_seen && err_fwd_en_q;
		end
	end

	// Downstream port resets, active low
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prst_n_q <= '1;
		end else if (!sec_rst_q) begin
			prst_n_q <= '1;
		end else if (is_downstream) begin
			prst_n_q <= {{(DN_PORTS-1){1'b1}}, 1'b0};
		end else begin
			prst_n_q <= '0;
		end
	end
	assign inta_assert = inta_q;
	assign poison_report = poison_q;
	assign err_msg_fwd = err_q;
	assign hot_reset_req = sec_rst_q;
	assign port_rst_n = prst_n_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_pf_readback;
		wr_pf ##1 (!reg_wr && reg_rd && reg_addr == BWCR_OFF_PF_TOP_HIGH)
			|=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_pf_readback: assert property (p_pf_readback) else $error("pf rb");
	property p_io_readback;
		wr_io ##1 (!reg_wr && reg_rd && reg_addr == BWCR_OFF_IO_HIGH)
			|=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_io_readback: assert property (p_io_readback) else $error("io rb");
	property p_cap;
		reg_rd && reg_addr == BWCR_OFF_CAP_START |=> reg_rdata == 32'h0000_0040;
	endproperty
	a_cap: assert property (p_cap) else $error("cap start wrong");
	property p_fixed_zero;
		reg_rd && reg_addr == BWCR_OFF_IRQ_BCTL
			|=> reg_rdata[31:23] == 9'h000 && !reg_rdata[21];
	endproperty
	a_fixed_zero: assert property (p_fixed_zero) else $error("ro bits");
	property p_rd_quiet;
		!reg_rd |=> reg_rdata == 32'h0000_0000;
	endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("rdata idle");
	property p_err_fwd;
		err_msg_seen && err_fwd_en_q |=> err_msg_fwd;
	endproperty
	a_err_fwd: assert property (p_err_fwd) else $error("err not fwd");
	property p_poison_off;
		!poison_en_q |=> !poison_report;
	endproperty
	a_poison_off: assert property (p_poison_off) else $error("poison");
	property p_isa_split;
		io_req_valid && isa_en_q && isa_alias && io_in_win
			|=> io_fwd_up && !io_fwd_down;
	endproperty
	a_isa_split: assert property (p_isa_split) else $error("isa bad");
	property p_io_down;
		io_req_valid && !isa_en_q && io_in_win |=> io_fwd_down;
	endproperty
	a_io_down: assert property (p_io_down) else $error("io down");
	property p_rst_dn;
		wr_irq && reg_wdata[BWCR_BC_SECRST] && is_downstream
			##1 (is_downstream && !wr_irq) |=> !port_rst_n[0] && hot_reset_req;
	endproperty
	a_rst_dn: assert property (p_rst_dn) else $error("dn reset");
	property p_rst_up;
		wr_irq && reg_wdata[BWCR_BC_SECRST] && !is_downstream
			##1 (!is_downstream && !wr_irq) |=> port_rst_n == '0;
	endproperty
	a_rst_up: assert property (p_rst_up) else $error("up reset");
	property p_vga_mem;
		!io_req_valid && mem_req_valid && vga_en_q
			&& mem_req_addr == 64'h0000_0000_000A_0000 |=> vga_fwd;
	endproperty
	a_vga_mem: assert property (p_vga_mem) else $error("vga mem miss");

	c_isa_up: cover property (io_fwd_up);
	c_vga_io: cover property (io_req_valid ##1 vga_fwd);
	c_hot_reset: cover property (hot_reset_req ##1 !hot_reset_req);
	c_pin_load: cover property (pin_load_valid && is_downstream);

endmodule : bwcr_regs

`default_nettype wire

// >>> test/bwcr_far_model.sv
// Secondary-side event source facing the bridge register bank
`timescale 1ns/10ps
`default_nettype none

module bwcr_far_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Event requests from the bench
	input wire logic [2:0] ev_req,
	// Event lines toward the bridge
	output logic hotplug_event,
	output logic poison_seen,
	output logic err_msg_seen
);
	// Events lag one cycle, as a real link would
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			{hotplug_event, poison_seen, err_msg_seen} <= 3'h0;
		end else begin
			{hotplug_event, poison_seen, err_msg_seen} <= ev_req;
		end
	end
endmodule : bwcr_far_model

`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the bridge window and control registers
`timescale 1ns/10ps
`default_nettype none

`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end

module tb;
	import bwcr_pkg::*;
	// --------------------------------------------------------------
	// Signals
	// --------------------------------------------------------------
	logic ref_clk = 1'b0, rst_n = 1'b0;
	logic [7:0] reg_addr, pin_load_value;
	logic [31:0] reg_wdata, reg_rdata, io_req_addr;
	logic reg_wr, reg_rd, is_downstream, pin_load_valid;
	logic hotplug_event, poison_seen, err_msg_seen, io_req_valid;
	logic [15:0] io_bottom_low, io_top_low;
	logic mem_req_valid, io_fwd_down, io_fwd_up, vga_fwd;
	logic [63:0] mem_req_addr;
	logic [11:0] pf_top_mid;
	logic mem_below_pf_top, dec_valid, inta_assert, poison_report;
	logic err_msg_fwd, hot_reset_req;
	logic [4:0] port_rst_n;
	logic [2:0] ev_req;
	int fail_count = 0, n_checks = 0, cyc = 0;

	// Clock and timeout
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	bwcr_far_model far (.ref_clk(ref_clk), .rst_n(rst_n), .ev_req(ev_req),
		.hotplug_event(hotplug_event), .poison_seen(poison_seen),
		.err_msg_seen(err_msg_seen));

	bwcr_regs #(.DN_PORTS(5)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.is_downstream(is_downstream), .pin_load_valid(pin_load_valid),
		.pin_load_value(pin_load_value), .hotplug_event(hotplug_event),
		.poison_seen(poison_seen), .err_msg_seen(err_msg_seen),
		.io_req_valid(io_req_valid), .io_req_addr(io_req_addr),
		.io_bottom_low(io_bottom_low), .io_top_low(io_top_low),
		.mem_req_valid(mem_req_valid), .mem_req_addr(mem_req_addr),
		.pf_top_mid(pf_top_mid), .io_fwd_down(io_fwd_down),
		.io_fwd_up(io_fwd_up), .vga_fwd(vga_fwd),
		.mem_below_pf_top(mem_below_pf_top), .dec_valid(dec_valid),
		.inta_assert(inta_assert), .poison_report(poison_report),
		.err_msg_fwd(err_msg_fwd), .hot_reset_req(hot_reset_req),
		.port_rst_n(port_rst_n));

	// --------------------------------------------------------------
	// Access tasks
	// --------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input string n);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 `CHK(n, e, reg_rdata)
	endtask : rd

	// Write then read back with no gap between the strobes
	task automatic wr_rd(input logic [7:0] a, input logic [31:0] d,
		input string n);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 `CHK(n, d, reg_rdata)
	endtask : wr_rd

	// One-cycle pulse on the interrupt pin load input
	task automatic pin_load(input logic [7:0] v);
		@(posedge ref_clk);
		pin_load_valid <= 1'b1;
		pin_load_value <= v;
		@(posedge ref_clk);
		pin_load_valid <= 1'b0;
	endtask : pin_load

	// One decode request; io gives {down, up, vga}, mem gives {vga, below}
	task automatic dec(input logic io, input logic [63:0] a,
		input logic [2:0] e);
		@(posedge ref_clk);
		io_req_valid <= io;
		mem_req_valid <= !io;
		io_req_addr <= a[31:0];
		mem_req_addr <= a;
		@(posedge ref_clk);
		io_req_valid <= 1'b0;
		mem_req_valid <= 1'b0;
		#1 `CHK("dec_valid", 1'b1, dec_valid)
		if (io) `CHK("io_dec", e, {io_fwd_down, io_fwd_up, vga_fwd})
		else `CHK("mem_dec", e[1:0], {vga_fwd, mem_below_pf_top})
	endtask : dec

	// Let registered outputs settle, then sample
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : settle

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish

	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		{reg_addr, reg_wdata, reg_wr, reg_rd, is_downstream} = '0;
		{pin_load_valid, pin_load_value, io_req_valid, io_req_addr} = '0;
		{mem_req_valid, mem_req_addr, pf_top_mid, ev_req} = '0;
		io_bottom_low = 16'h1000;
		io_top_low = 16'h1fff;
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		settle(1);
		`CHK("rst_out", 5'h1f, port_rst_n)
		rd(BWCR_OFF_PF_TOP_HIGH, 32'h0000_0000, "pf_rst");
		rd(BWCR_OFF_IO_HIGH, 32'h0000_0000, "io_rst");
		rd(BWCR_OFF_CAP_START, 32'h0000_0040, "cap_rst");
		rd(BWCR_OFF_IRQ_BCTL, 32'h0000_0000, "bctl_rst");
		wr_rd(BWCR_OFF_PF_TOP_HIGH, 32'ha5a5_5a5a, "pf_rw");
		wr_rd(BWCR_OFF_IO_HIGH, 32'h1234_5678, "io_rw");
		wr(BWCR_OFF_CAP_START, 32'hffff_ffff);
		rd(BWCR_OFF_CAP_START, 32'h0000_0040, "cap_ro");
		rd(8'h38, 32'h0000_0000, "unmapped");
		pin_load(8'h05);
		wr(BWCR_OFF_IRQ_BCTL, 32'hffff_ffff);
		rd(BWCR_OFF_IRQ_BCTL, 32'h005f_00ff, "bctl_rw");
		rd(BWCR_OFF_IRQ_BCTL, 32'h005f_00ff, "bctl_again");
		`CHK("hot_up", 6'h20, {hot_reset_req, port_rst_n})
		@(posedge ref_clk);
		ev_req <= 3'h7;
		wr(BWCR_OFF_IRQ_BCTL, 32'h0003_0000);
		settle(3);
		`CHK("ev_on", 3'h7, {inta_assert, poison_report, err_msg_fwd})
		`CHK("hot_off", 6'h1f, {hot_reset_req, port_rst_n})
		wr(BWCR_OFF_IRQ_BCTL, 32'h0000_0000);
		settle(2);
		`CHK("ev_off", 3'h4, {inta_assert, poison_report, err_msg_fwd})
		@(posedge ref_clk);
		ev_req <= 3'h0;
		is_downstream <= 1'b1;
		wr(BWCR_OFF_IRQ_BCTL, 32'h0040_0000);
		settle(2);
		`CHK("hot_dn", 6'h3e, {hot_reset_req, port_rst_n})
		`CHK("ev_idle", 3'h0, {inta_assert, poison_report, err_msg_fwd})
		pin_load(8'h01);
		rd(BWCR_OFF_IRQ_BCTL, 32'h0040_0100, "pin_load");
		wr(BWCR_OFF_IO_HIGH, 32'h0000_0000);
		wr(BWCR_OFF_PF_TOP_HIGH, 32'h0000_0001);
		wr(BWCR_OFF_IRQ_BCTL, 32'h0000_0000);
		dec(1'b1, 64'h1100, 3'h4);
		dec(1'b1, 64'h3000, 3'h0);
		wr(BWCR_OFF_IRQ_BCTL, 32'h0004_0000);
		dec(1'b1, 64'h1100, 3'h2);
		dec(1'b1, 64'h1000, 3'h4);
		wr(BWCR_OFF_IRQ_BCTL, 32'h0008_0000);
		dec(1'b1, 64'h07c0, 3'h1);
		dec(1'b1, 64'h03bc, 3'h0);
		dec(1'b0, 64'h000a_0000, 3'h3);
		dec(1'b0, 64'h000c_0000, 3'h1);
		dec(1'b0, 64'h0000_0001_000f_ffff, 3'h1);
		dec(1'b0, 64'h0000_0001_0010_0000, 3'h0);
		@(posedge ref_clk);
		pf_top_mid <= 12'h001;
		dec(1'b0, 64'h0000_0001_001f_ffff, 3'h1);
		dec(1'b0, 64'h0000_0001_0020_0000, 3'h0);
		wr(BWCR_OFF_IRQ_BCTL, 32'h0018_0000);
		dec(1'b1, 64'h07c0, 3'h0);
		dec(1'b1, 64'h03c0, 3'h1);
		wr(BWCR_OFF_IRQ_BCTL, 32'h0000_0000);
		dec(1'b0, 64'h000a_0000, 3'h1);
		settle(1);
		`CHK("dec_idle", 3'h0, {dec_valid, vga_fwd, mem_below_pf_top})
		tally_and_finish();
	end
endmodule : tb

`default_nettype wire
